// ### mbs_server.sv
// mbs_server: modbus pdu decoder and dispatcher over one word store
`timescale 1ns/1ps
module mbs_server #(
   parameter int N_IN  = 16,
   parameter int N_OUT = 16,
   parameter int MAXB  = 64
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 arst_n_i,
   input  wire logic                 rq_valid_i,
   input  wire logic [7:0]           rq_data_i,
   input  wire logic                 rq_last_i,
   output logic                      rq_ready_o,
   output logic                      rs_valid_o,
   output logic [7:0]                rs_data_o,
   output logic                      rs_last_o,
   input  wire logic                 rs_ready_i,
   input  wire logic [N_IN*16-1:0]   in_area_i,
   output logic [N_OUT*16-1:0]       out_area_o,
   output logic                      out_upd_o
);
   localparam int NW = $clog2(MAXB) + 1;
   localparam logic [NW-1:0] MAXN = NW'(MAXB);
   localparam logic [16:0] LIW = 17'(N_IN);
   localparam logic [16:0] LIB = 17'(N_IN * 16);
   localparam logic [16:0] LOW = 17'(N_OUT);
   localparam logic [16:0] LOB = 17'(N_OUT * 16);

   typedef struct packed {
      mbs_pkg::mbs_state_type st;
      logic [NW-1:0]          n;
      logic                   ovf;
      logic [MAXB-1:0][7:0]   rx;
      logic [MAXB-1:0][7:0]   tx;
      logic [NW-1:0]          tlen;
      logic [NW-1:0]          tidx;
      logic [N_OUT*16-1:0]    outw;
      logic [N_OUT*16-1:0]    outp;
      logic                   upd;
   } mbs_regs_type;

   mbs_regs_type s_q;
   mbs_regs_type s_d;
   logic [1:0]   rst_q;
   logic         rst_n;

   // every check below runs on the system clock and sleeps in reset
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n);

   // **************************************************
   // reset release
   // **************************************************
   // async assert, release through two flops
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // **************************************************
   // request field views
   // **************************************************
   logic [7:0]  fc;
   logic [15:0] a;
   logic [15:0] q;
   logic [15:0] wa;
   logic [15:0] wq;
   logic [7:0]  exc;
   // all addresses are plain unsigned offsets from zero
   assign fc = s_q.rx[0];
   assign a  = {s_q.rx[1], s_q.rx[2]};
   assign q  = {s_q.rx[3], s_q.rx[4]};
   assign wa = {s_q.rx[5], s_q.rx[6]};
   assign wq = {s_q.rx[7], s_q.rx[8]};

   // true when the span sits wholly inside the area
   function automatic logic fits(input logic [15:0] ad,
                                 input logic [15:0] qt,
                                 input logic [15:0] base,
                                 input logic [16:0] lim);
      fits = (ad >= base) &&
             (({1'b0, ad} - {1'b0, base} + {1'b0, qt}) <= lim);
   endfunction

   // one bit of either area; out of range reads as zero
   function automatic logic pick(input logic so, input int idx);
      if (so) pick = (idx >= 0 && idx < N_OUT * 16) ? s_q.outw[idx] : 1'b0;
      else pick = (idx >= 0 && idx < N_IN * 16) ? in_area_i[idx] : 1'b0;
   endfunction

   // **************************************************
   // validation: function, then value, then address
   // **************************************************
   always_comb begin
      logic [15:0] need;
      logic [15:0] b5;
      logic [15:0] b9;
      need = mbs_pkg::LEN_FIX;
      b5   = {8'h00, s_q.rx[5]};
      b9   = {8'h00, s_q.rx[9]};
      exc  = mbs_pkg::EXC_NONE;
      case (fc)
         mbs_pkg::FC_RD_COIL, mbs_pkg::FC_RD_DIN: begin
            if (q == 16'h0000 || q > mbs_pkg::MAX_BITS)
               exc = mbs_pkg::EXC_VAL;
            else if (fc == mbs_pkg::FC_RD_COIL ?
                     !fits(a, q, mbs_pkg::COIL_BASE, LOB) :
                     !fits(a, q, mbs_pkg::IN_BASE, LIB))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_RD_HOLD, mbs_pkg::FC_RD_INREG: begin
            if (q == 16'h0000 || q > mbs_pkg::MAX_WORDS)
               exc = mbs_pkg::EXC_VAL;
            else if (fc == mbs_pkg::FC_RD_HOLD && a >= mbs_pkg::OUT_BASE ?
                     !fits(a, q, mbs_pkg::OUT_BASE, LOW) :
                     !fits(a, q, mbs_pkg::IN_BASE, LIW))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_WR_COIL: begin
            if (q != mbs_pkg::COIL_ON && q != mbs_pkg::COIL_OFF)
               exc = mbs_pkg::EXC_VAL;
            else if (!fits(a, 16'h0001, mbs_pkg::COIL_BASE, LOB))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_WR_REG, mbs_pkg::FC_MASK_WR: begin
            if (fc == mbs_pkg::FC_MASK_WR) need = mbs_pkg::LEN_MASK;
            if (!fits(a, 16'h0001, mbs_pkg::OUT_BASE, LOW))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_WR_COILS: begin
            need = mbs_pkg::LEN_MULTI + b5;
            if (q == 16'h0000 || q > mbs_pkg::MAX_BITS ||
                b5 != ((q + 16'h0007) >> 3))
               exc = mbs_pkg::EXC_VAL;
            else if (!fits(a, q, mbs_pkg::COIL_BASE, LOB))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_WR_REGS: begin
            need = mbs_pkg::LEN_MULTI + b5;
            if (q == 16'h0000 || q > mbs_pkg::MAX_WORDS || b5 != (q << 1))
               exc = mbs_pkg::EXC_VAL;
            else if (!fits(a, q, mbs_pkg::OUT_BASE, LOW))
               exc = mbs_pkg::EXC_ADDR;
         end
         mbs_pkg::FC_RW_REGS: begin
            need = mbs_pkg::LEN_RW + b9;
            if (q == 16'h0000 || q > mbs_pkg::MAX_WORDS ||
                wq == 16'h0000 || wq > mbs_pkg::MAX_WORDS ||
                b9 != (wq << 1))
               exc = mbs_pkg::EXC_VAL;
            else if (!fits(a, q, mbs_pkg::IN_BASE, LIW) ||
                     !fits(wa, wq, mbs_pkg::OUT_BASE, LOW))
               exc = mbs_pkg::EXC_ADDR;
         end
         default: exc = mbs_pkg::EXC_FUNC;
      endcase
      // a short or overlong frame is bad data, not a bad address
      if (exc != mbs_pkg::EXC_FUNC && (s_q.ovf || 16'(s_q.n) < need))
         exc = mbs_pkg::EXC_VAL;
   end

   // **************************************************
   // sequencing, execution and answer build
   // **************************************************
   always_comb begin
      logic        so;
      logic        wrd;
      int          st0;
      int          cnt;
      int          db;
      int          k;
      logic [15:0] bc;
      s_d     = s_q;
      s_d.upd = 1'b0;
      so      = 1'b0;
      wrd     = 1'b0;
      st0     = 0;
      cnt     = 0;
      db      = 0;
      k       = 0;
      bc      = 16'h0000;
      case (s_q.st)
         mbs_pkg::ST_RX: begin
            if (rq_valid_i) begin
               if (s_q.n < MAXN) begin
                  s_d.rx[s_q.n] = rq_data_i;
                  s_d.n         = s_q.n + 1'b1;
               end else s_d.ovf = 1'b1;
               if (rq_last_i) s_d.st = mbs_pkg::ST_EX;
            end
         end
         mbs_pkg::ST_EX: begin
            s_d.tx    = '0;
            s_d.tx[0] = fc;
            s_d.tidx  = '0;
            s_d.st    = mbs_pkg::ST_TX;
            if (exc != mbs_pkg::EXC_NONE) begin
               s_d.tx[0] = fc | mbs_pkg::EXC_FLAG;
               s_d.tx[1] = exc;
               s_d.tlen  = NW'(mbs_pkg::HDR_RSP);
            end else begin
               // word writes: single, multiple, combined
               if (fc == mbs_pkg::FC_WR_REG || fc == mbs_pkg::FC_WR_REGS ||
                   fc == mbs_pkg::FC_RW_REGS) begin
                  st0 = int'(((fc == mbs_pkg::FC_RW_REGS) ? wa : a) -
                             mbs_pkg::OUT_BASE);
                  cnt = (fc == mbs_pkg::FC_WR_REG) ? 1 :
                        int'((fc == mbs_pkg::FC_RW_REGS) ? wq : q);
                  db  = (fc == mbs_pkg::FC_WR_REG) ? mbs_pkg::DAT_ONE :
                        (fc == mbs_pkg::FC_RW_REGS) ? mbs_pkg::DAT_RW :
                        mbs_pkg::DAT_MULTI;
                  for (int i = 0; i < N_OUT; i++) begin
                     k = i - st0;
                     if (k >= 0 && k < cnt)
                        s_d.outw[i*16 +: 16] = {s_q.rx[db + 2*k],
                                                s_q.rx[db + 2*k + 1]};
                  end
               end
               // masked write: and with q, or with the second field masked by ~q
               if (fc == mbs_pkg::FC_MASK_WR) begin
                  st0 = int'(a - mbs_pkg::OUT_BASE);
                  for (int i = 0; i < N_OUT; i++)
                     if (i == st0)
                        s_d.outw[i*16 +: 16] = (s_q.outw[i*16 +: 16] & q) |
                                               (wa & ~q);
               end
               // coil writes land on bits of the holding words
               if (fc == mbs_pkg::FC_WR_COIL || fc == mbs_pkg::FC_WR_COILS) begin
                  st0 = int'(a - mbs_pkg::COIL_BASE);
                  cnt = (fc == mbs_pkg::FC_WR_COIL) ? 1 : int'(q);
                  for (int j = 0; j < N_OUT * 16; j++) begin
                     k = j - st0;
                     if (k >= 0 && k < cnt)
                        s_d.outw[j] = (fc == mbs_pkg::FC_WR_COIL) ?
                           (q == mbs_pkg::COIL_ON) :
                           s_q.rx[mbs_pkg::DAT_MULTI + k/8][k%8];
                  end
               end
               // reads: word or bit, from input or output area
               case (fc)
                  mbs_pkg::FC_RD_COIL: begin
                     so = 1'b1;
                     st0 = int'(a - mbs_pkg::COIL_BASE);
                  end
                  mbs_pkg::FC_RD_DIN: st0 = int'(a);
                  mbs_pkg::FC_RD_HOLD: begin
                     wrd = 1'b1;
                     so  = (a >= mbs_pkg::OUT_BASE);
                     st0 = int'(so ? a - mbs_pkg::OUT_BASE : a);
                  end
                  mbs_pkg::FC_RD_INREG, mbs_pkg::FC_RW_REGS: begin
                     wrd = 1'b1;
                     st0 = int'(a);
                  end
                  default: st0 = 0;
               endcase
               if (fc <= mbs_pkg::FC_RD_INREG || fc == mbs_pkg::FC_RW_REGS)
               begin
                  // combined read takes the input area, which this write never touches
                  bc = wrd ? (q << 1) : ((q + 16'h0007) >> 3);
                  s_d.tx[1] = bc[7:0];
                  s_d.tlen  = NW'(bc + 16'(mbs_pkg::HDR_RSP));
                  for (int b = 0; b < MAXB - mbs_pkg::HDR_RSP; b++)
                     for (int t = 0; t < 8; t++)
                        if (wrd ? (b < int'(bc)) : (8*b + t < int'(q)))
                           s_d.tx[b + mbs_pkg::HDR_RSP][t] = wrd ?
                              pick(so, (st0 + b/2)*16 +
                                   ((b%2 == 0) ? 8 : 0) + t) :
                              pick(so, st0 + 8*b + t);
               end else begin
                  // write answers echo the request header
                  for (int b = 1; b < int'(mbs_pkg::LEN_MASK); b++)
                     s_d.tx[b] = s_q.rx[b];
                  s_d.tlen = (fc == mbs_pkg::FC_MASK_WR) ?
                             NW'(mbs_pkg::LEN_MASK) : NW'(mbs_pkg::LEN_FIX);
               end
            end
         end
         mbs_pkg::ST_TX: begin
            if (rs_ready_i) begin
               s_d.tidx = s_q.tidx + 1'b1;
               if (s_q.tidx == s_q.tlen - 1'b1) begin
                  // publish written words only once answered
                  s_d.outp = s_q.outw;
                  s_d.upd  = 1'b1;
                  s_d.n    = '0;
                  s_d.ovf  = 1'b0;
                  s_d.st   = mbs_pkg::ST_RX;
               end
            end
         end
         default: s_d.st = mbs_pkg::ST_RX;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end

   assign rq_ready_o = (s_q.st == mbs_pkg::ST_RX);
   assign rs_valid_o = (s_q.st == mbs_pkg::ST_TX);
   assign rs_data_o  = s_q.tx[s_q.tidx];
   assign rs_last_o  = rs_valid_o && (s_q.tidx == s_q.tlen - 1'b1);
   assign out_area_o = s_q.outp;
   assign out_upd_o  = s_q.upd;

   // **************************************************
   // checks
   // **************************************************
   logic ex;
   assign ex = (s_q.st == mbs_pkg::ST_EX);
   sequence tx_end;
      rs_valid_o && rs_ready_i && rs_last_o;
   endsequence
   sequence publish;
      out_upd_o && out_area_o == $past(s_q.outw) ##1 !out_upd_o;
   endsequence

   AST_BAD_FUNC: assert property (
      ex && exc == mbs_pkg::EXC_FUNC |=> s_q.tx[1] == 8'h01 &&
      s_q.tx[0] == ($past(fc) | 8'h80) && s_q.tlen == NW'(2))
      else $error("unsupported code not answered with 01");
   AST_EXC_FORM: assert property (
      ex && exc != mbs_pkg::EXC_NONE |=> s_q.tx[0][7] && rs_valid_o)
      else $error("exception reply lacks flagged code");
   AST_IN_WRITE: assert property (
      ex && fc == mbs_pkg::FC_WR_REG && a < 16'h0400 && s_q.n == NW'(5)
      |=> s_q.tx[1] == 8'h02)
      else $error("write to input area not refused with 02");
   AST_HOLD_WR: assert property (
      ex && fc == mbs_pkg::FC_WR_REG && exc == 8'h00 && a == 16'h0400
      |=> s_q.outw[15:0] == $past(q) && out_area_o == $past(out_area_o))
      else $error("holding word 1024 not written or published early");
   AST_COIL_ALIAS: assert property (
      ex && fc == mbs_pkg::FC_WR_COIL && exc == 8'h00 && a == 16'h4000
      |=> s_q.outw[0] == ($past(q) == 16'hFF00))
      else $error("coil 16384 is not bit 0 of first holding word");
   AST_DIN_BIT0: assert property (
      ex && fc == mbs_pkg::FC_RD_DIN && exc == 8'h00 && a == 16'h0000
      |=> s_q.tx[2][0] == $past(in_area_i[0]))
      else $error("discrete input 0 differs from input word 0 bit 0");
   AST_WORD3: assert property (
      ex && fc == mbs_pkg::FC_RW_REGS && exc == 8'h00 && a == 16'h0003
      |=> s_q.tx[2] == $past(in_area_i[63:56]) &&
          s_q.tx[3] == $past(in_area_i[55:48]))
      else $error("combined read of word 3 is not inputs 48 to 63");
   AST_PUBLISH: assert property (
      tx_end |=> publish)
      else $error("written words not published after the answer");
   AST_HOLD_OUT: assert property (
      rs_valid_o && !rs_ready_i |=> rs_valid_o && $stable(rs_data_o))
      else $error("answer byte changed while stalled");
endmodule // mbs_server

// ### mbs_pkg.sv
// mbs_pkg: constants and types of the modbus register map server
package mbs_pkg;
   // **************************************************
   // address map
   // **************************************************
   localparam logic [15:0] IN_BASE   = 16'h0000;
   localparam logic [15:0] OUT_BASE  = 16'h0400;
   localparam logic [15:0] COIL_BASE = 16'h4000;
   // **************************************************
   // function and exception codes
   // **************************************************
   localparam logic [7:0] FC_RD_COIL  = 8'h01;
   localparam logic [7:0] FC_RD_DIN   = 8'h02;
   localparam logic [7:0] FC_RD_HOLD  = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL  = 8'h05;
   localparam logic [7:0] FC_WR_REG   = 8'h06;
   localparam logic [7:0] FC_WR_COILS = 8'h0F;
   localparam logic [7:0] FC_WR_REGS  = 8'h10;
   localparam logic [7:0] FC_MASK_WR  = 8'h16;
   localparam logic [7:0] FC_RW_REGS  = 8'h17;
   localparam logic [7:0] EXC_NONE    = 8'h00;
   localparam logic [7:0] EXC_FUNC    = 8'h01;
   localparam logic [7:0] EXC_ADDR    = 8'h02;
   localparam logic [7:0] EXC_VAL     = 8'h03;
   localparam logic [7:0] EXC_FLAG    = 8'h80;
   // **************************************************
   // quantity limits, coil values and pdu layout
   // **************************************************
   localparam logic [15:0] MAX_WORDS = 16'h007D;
   localparam logic [15:0] MAX_BITS  = 16'h07D0;
   localparam logic [15:0] COIL_ON   = 16'hFF00;
   localparam logic [15:0] COIL_OFF  = 16'h0000;
   localparam logic [15:0] LEN_FIX   = 16'h0005;
   localparam logic [15:0] LEN_MULTI = 16'h0006;
   localparam logic [15:0] LEN_MASK  = 16'h0007;
   localparam logic [15:0] LEN_RW    = 16'h000A;
   localparam int          DAT_ONE   = 3;
   localparam int          DAT_MULTI = 6;
   localparam int          DAT_RW    = 10;
   localparam int          HDR_RSP   = 2;
   // states, gray along receive, execute, transmit
   typedef enum logic [1:0] {
      ST_RX = 2'b00,
      ST_EX = 2'b01,
      ST_TX = 2'b11
   } mbs_state_type;
endpackage

// ### mbs_host.sv
// mbs_host: behavioural modbus client that feeds and drains the pdu streams
`timescale 1ns/1ps
module mbs_host (
   input  wire logic       clk_i,
   output logic            rq_valid_o,
   output logic [7:0]      rq_data_o,
   output logic            rq_last_o,
   input  wire logic       rq_ready_i,
   input  wire logic       rs_valid_i,
   input  wire logic [7:0] rs_data_i,
   input  wire logic       rs_last_i,
   output logic            rs_ready_o
);
   logic slow = 1'b0;  // set: take answer bytes every other cycle only
   // idle levels at time zero
   initial begin
      rq_valid_o = 1'b0;
      rq_data_o  = 8'h00;
      rq_last_o  = 1'b0;
      rs_ready_o = 1'b0;
   end
   // one request sent whole, held until taken, then its answer drained
   task automatic xact(input logic [7:0] rq[$], output logic [7:0] rs[$]);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      rs = {};
      foreach (rq[i]) begin
         rq_valid_o <= 1'b1;
         rq_data_o  <= rq[i];
         rq_last_o  <= (i == rq.size() - 1);
         do @(posedge clk_i); while (!rq_ready_i);
      end
      // released data shows the inverse, never a stale copy of the last byte
      rq_valid_o <= 1'b0;
      rq_data_o  <= ~rq_data_o;
      rq_last_o  <= 1'b0;
      rs_ready_o <= 1'b1;
      while (!done && n < 400) begin
         @(posedge clk_i);
         n++;
         if (rs_valid_i && rs_ready_o) begin
            rs.push_back(rs_data_i);
            done = rs_last_i;
         end
         rs_ready_o <= (slow && !done) ? ~rs_ready_o : !done;
      end
   endtask
endmodule // mbs_host

// ### tb_mbs_server.sv
// tb_mbs_server: self-checking bench for the modbus register map server
`timescale 1ns/1ps
module tb_mbs_server;
   logic          clk_sys_i = 1'b0;
   logic          arst_n_i  = 1'b0;
   logic          rq_valid, rq_last, rq_ready, rs_valid, rs_last, rs_ready;
   logic [7:0]    rq_data, rs_data;
   logic [63:0]   in_area_i = 64'h8001_5AA5_00F0_C0DE;
   logic [63:0]   out_area_o;
   logic          out_upd_o;
   int            miscompares = 0;
   int            num_checks = 0;
   int            cycles = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   mbs_server #(.N_IN(4), .N_OUT(4), .MAXB(64)) dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .rq_valid_i(rq_valid),
      .rq_data_i(rq_data), .rq_last_i(rq_last), .rq_ready_o(rq_ready),
      .rs_valid_o(rs_valid), .rs_data_o(rs_data), .rs_last_o(rs_last),
      .rs_ready_i(rs_ready), .in_area_i(in_area_i),
      .out_area_o(out_area_o), .out_upd_o(out_upd_o));
   mbs_host host (
      .clk_i(clk_sys_i), .rq_valid_o(rq_valid), .rq_data_o(rq_data),
      .rq_last_o(rq_last), .rq_ready_i(rq_ready), .rs_valid_i(rs_valid),
      .rs_data_i(rs_data), .rs_last_i(rs_last), .rs_ready_o(rs_ready));
   // **************************************************
   // compare helpers and verdict
   // **************************************************
   task automatic complete_run;
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_bytes(input logic [7:0] got[$], input logic [7:0] exp[$]);
      num_checks++;
      if (got.size() != exp.size()) begin
         miscompares++;
         $display("CHECK FAILED t=%0t len %h exp %h", $time, got.size(),
                  exp.size());
      end else foreach (exp[i]) if (got[i] !== exp[i]) begin
         miscompares++;
         $display("CHECK FAILED t=%0t byte %h exp %h", $time, got[i], exp[i]);
         break;
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
      end
   endtask
   // one request and its expected answer, addresses zero-based
   task automatic run(input logic [7:0] rq[$], input logic [7:0] exp[$]);
      logic [7:0] rs[$];
      host.xact(rq, rs);
      chk_bytes(rs, exp);
   endtask
   // let the published copy refresh after the answer has gone; the
   // update strobe lasts one cycle, so it is looked at mid-cycle
   task automatic settle;
      @(negedge clk_sys_i);
      chk_word(16'(out_upd_o), 16'h0001);
      @(negedge clk_sys_i);
      chk_word(16'(out_upd_o), 16'h0000);
      @(posedge clk_sys_i);
   endtask
   // **************************************************
   // scenarios
   // **************************************************
   task automatic sc_reads;
      run({8'h04, 8'h00, 8'h00, 8'h00, 8'h04}, {8'h04, 8'h08, 8'hC0, 8'hDE,
          8'h00, 8'hF0, 8'h5A, 8'hA5, 8'h80, 8'h01});
      run({8'h02, 8'h00, 8'h30, 8'h00, 8'h10},
          {8'h02, 8'h02, 8'h01, 8'h80});
      run({8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
          {8'h03, 8'h02, 8'hC0, 8'hDE});
      run({8'h02, 8'h00, 8'h00, 8'h00, 8'h08},
          {8'h02, 8'h01, 8'hDE});
   endtask
   task automatic sc_words;
      run({8'h06, 8'h04, 8'h00, 8'h12, 8'h34},
          {8'h06, 8'h04, 8'h00, 8'h12, 8'h34});
      settle();
      chk_word(out_area_o[15:0], 16'h1234);
      run({8'h10, 8'h04, 8'h03, 8'h00, 8'h01, 8'h02, 8'hBE, 8'hEF},
          {8'h10, 8'h04, 8'h03, 8'h00, 8'h01});
      run({8'h16, 8'h04, 8'h03, 8'h00, 8'hFF, 8'h12, 8'h00}, {8'h16, 8'h04,
          8'h03, 8'h00, 8'hFF, 8'h12, 8'h00});
      run({8'h03, 8'h04, 8'h03, 8'h00, 8'h01},
          {8'h03, 8'h02, 8'h12, 8'hEF});
   endtask
   // slow consumer for the coil runs: every answer byte waits a stalled cycle; the closing read runs at full rate
   task automatic sc_coils;
      host.slow = 1'b1;
      run({8'h05, 8'h40, 8'h11, 8'hFF, 8'h00},
          {8'h05, 8'h40, 8'h11, 8'hFF, 8'h00});
      run({8'h0F, 8'h40, 8'h20, 8'h00, 8'h08, 8'h01, 8'hA5},
          {8'h0F, 8'h40, 8'h20, 8'h00, 8'h08});
      run({8'h05, 8'h40, 8'h00, 8'hFF, 8'h00},
          {8'h05, 8'h40, 8'h00, 8'hFF, 8'h00});
      run({8'h01, 8'h40, 8'h00, 8'h00, 8'h18},
          {8'h01, 8'h03, 8'h35, 8'h12, 8'h02});
      run({8'h05, 8'h40, 8'h00, 8'h00, 8'h00},
          {8'h05, 8'h40, 8'h00, 8'h00, 8'h00});
      host.slow = 1'b0;
      run({8'h03, 8'h04, 8'h02, 8'h00, 8'h01},
          {8'h03, 8'h02, 8'h00, 8'hA5});
   endtask
   task automatic sc_combined;
      run({8'h17, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00, 8'h01,
          8'h02, 8'h55, 8'h55}, {8'h17, 8'h02, 8'hC0, 8'hDE});
      settle();
      chk_word(out_area_o[31:16], 16'h5555);
      run({8'h17, 8'h00, 8'h03, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00, 8'h01,
          8'h02, 8'hAA, 8'hAA}, {8'h17, 8'h02, 8'h80, 8'h01});
      settle();
      chk_word(out_area_o[31:16], 16'hAAAA);
   endtask
   task automatic sc_exceptions;
      run({8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h87, 8'h01});
      run({8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, {8'h83, 8'h02});
      run({8'h04, 8'h00, 8'h03, 8'h00, 8'h02}, {8'h84, 8'h02});
      run({8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h84, 8'h03});
      run({8'h05, 8'h40, 8'h00, 8'h12, 8'h34}, {8'h85, 8'h03});
      run({8'h06, 8'h00, 8'h02, 8'h00, 8'h01}, {8'h86, 8'h02});
      run({8'h05, 8'h00, 8'h01, 8'hFF, 8'h00}, {8'h85, 8'h02});
      run({8'h06, 8'h04, 8'h00}, {8'h86, 8'h03});
      settle();
      chk_word(out_area_o[15:0], 16'h1234);
   endtask
   // hang guard: the whole run needs a few thousand cycles at most
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   // reset for three cycles, wait out the release flops, then the scenarios
   initial begin
      repeat (3) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      sc_reads();
      sc_words();
      sc_coils();
      sc_combined();
      sc_exceptions();
      complete_run();
   end
endmodule // tb_mbs_server
